/* File: core/pattern_generator.sv */
// Function
// - Bar enable gives eight vertical colour bars
// - Reverse bit swaps the yellow and blue bands
// - Pixels are produced only while enabled
// - 18-bit mode: 64 levels, six MSBs
// - 24-bit mode: 256 brightness levels
// - Clock source picks external or divided tick
// - Clock source ignored under external timing
// - Internal timing from programmed frame shape
// - External timing follows incoming pixel signals
// - Invert bit inverts the selected pattern
// - Auto-scroll advances after programmed frame count
// - Without auto-scroll the pattern stays
// - Fixed select shown without auto-scroll and seeds the auto-scroll start
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ps
module pattern_generator
   import pattern_gen_pkg::*;
#(
   parameter int          DIVIDE = DIV_DEFAULT,
   parameter int          DEPTH  = FIFO_DEPTH,
   parameter logic [23:0] CUSTOM = 24'h808080
) (
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // AXI4-Lite write
   input  wire logic [11:0] awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   // AXI4-Lite read
   input  wire logic [11:0] araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   // External video timing
   input  wire logic        ext_pixel_valid,
   output logic             ext_ready,
   input  wire logic        ext_de,
   input  wire logic        ext_hs,
   input  wire logic        ext_vs,
   // Video out
   output logic             video_valid,
   input  wire logic        video_ready,
   output logic             video_de,
   output logic             video_hs,
   output logic             video_vs,
   output logic [7:0]       video_red,
   output logic [7:0]       video_green,
   output logic [7:0]       video_blue,
   // Transmitter control
   output logic             serial_tx_power_down
);
   localparam int DW = $clog2(DIVIDE + 1);

   logic [7:0]  tx_ctl_reg;
   logic [7:0]  ctl_reg;
   logic [7:0]  cfg_reg;
   logic [31:0] htime_reg;
   logic [31:0] vtime_reg;
   logic [31:0] sync_reg;
   logic [31:0] scroll_reg;
   logic        aw_held_reg;
   logic [9:0]  aw_idx_reg;
   logic        w_held_reg;
   logic [31:0] wdata_reg;
   logic [3:0]  wstrb_reg;
   logic        bvalid_reg;
   logic [1:0]  bresp_reg;
   logic        rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0]  rresp_reg;
   logic        do_write;
   logic        wr_mapped;
   logic [31:0] rd_word;
   logic        rd_mapped;
   logic [DW-1:0] div_reg;
   logic        div_tick;
   logic        pix_tick;
   logic        step;
   logic        fifo_ready;
   logic        tg_de;
   logic        tg_hs;
   logic        tg_vs;
   logic        tg_frame;
   logic        cur_de;
   logic        cur_hs;
   logic        cur_vs;
   logic        ext_vs_act;
   logic        prev_de_reg;
   logic        prev_vs_reg;
   logic        frame_begin;
   logic        line_end;
   logic [20:0] st_reg [4];
   logic [8:0]  levels;
   logic [3:0]  scroll_pat_reg;
   logic [7:0]  frame_cnt_reg;
   logic [3:0]  pattern_sel;
   logic [7:0]  h_ramp;
   logic [7:0]  v_ramp;
   logic [7:0]  ramp;
   logic [23:0] base;
   logic [23:0] shown;
   logic [PIX_W-1:0] pixel;
   logic [PIX_W-1:0] out_word;

   wire enable = ctl_reg[CTL_ENABLE];
   wire tsel   = cfg_reg[CFG_TSEL];
   wire auto   = cfg_reg[CFG_AUTO];
   wire eight  = cfg_reg[CFG_18B];
   wire [TIME_W-1:0] h_active = htime_reg[TIME_ACTIVE_LSB +: TIME_W];
   wire [TIME_W-1:0] v_active = vtime_reg[TIME_ACTIVE_LSB +: TIME_W];

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                         input logic [3:0] strb);
      for (int b = 0; b < 4; b++)
         merge[8*b +: 8] = strb[b] ? data[8*b +: 8] : old[8*b +: 8];
   endfunction : merge

   // One accumulator step; overflowing the span moves the index on by one
   function automatic logic [20:0] acc_step(input logic [20:0] st, input logic [8:0] steps,
                                            input logic [11:0] span);
      logic [12:0] sum;
      sum = {1'b0, st[11:0]} + {4'h0, steps};
      if (sum >= {1'b0, span})
         acc_step = {st[20:12] + 9'h001, 12'(sum - {1'b0, span})};
      else
         acc_step = {st[20:12], sum[11:0]};
   endfunction : acc_step

   // Write channel: address and data are caught independently, in either order
   assign awready   = !aw_held_reg;
   assign wready    = !w_held_reg;
   assign do_write  = aw_held_reg && w_held_reg && !bvalid_reg;
   assign wr_mapped = aw_idx_reg inside {IDX_TX_CTL, IDX_CTL, IDX_CFG, IDX_HTIME, IDX_VTIME,
                                         IDX_SYNC, IDX_SCROLL, IDX_STATUS};
   assign bvalid    = bvalid_reg;
   assign bresp     = bresp_reg;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held_reg <= 1'b0;
         aw_idx_reg  <= '0;
      end
      else if (awvalid && awready)
      begin
         aw_held_reg <= 1'b1;
         aw_idx_reg  <= awaddr[11:2];
      end
      else if (do_write)
         aw_held_reg <= 1'b0;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         w_held_reg <= 1'b0;
         wdata_reg  <= '0;
         wstrb_reg  <= '0;
      end
      else if (wvalid && wready)
      begin
         w_held_reg <= 1'b1;
         wdata_reg  <= wdata;
         wstrb_reg  <= wstrb;
      end
      else if (do_write)
         w_held_reg <= 1'b0;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bvalid_reg <= 1'b0;
         bresp_reg  <= RESP_OKAY;
      end
      else if (do_write)
      begin
         bvalid_reg <= 1'b1;
         bresp_reg  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bready)
         bvalid_reg <= 1'b0;
   end

   // Register stores; status is read-only and writes to it are accepted but dropped
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         tx_ctl_reg <= TX_CTL_RESET;
         ctl_reg    <= CTL_RESET;
         cfg_reg    <= CFG_RESET;
         htime_reg  <= HTIME_RESET;
         vtime_reg  <= VTIME_RESET;
         sync_reg   <= SYNC_RESET;
         scroll_reg <= SCROLL_RESET;
      end
      else if (do_write)
      begin
         unique case (aw_idx_reg)
            IDX_TX_CTL: tx_ctl_reg <= 8'(merge({24'h0, tx_ctl_reg}, wdata_reg, wstrb_reg))
                                      & 8'h01;
            IDX_CTL:    ctl_reg    <= 8'(merge({24'h0, ctl_reg}, wdata_reg, wstrb_reg));
            IDX_CFG:    cfg_reg    <= 8'(merge({24'h0, cfg_reg}, wdata_reg, wstrb_reg))
                                      & CFG_WMASK;
            IDX_HTIME:  htime_reg  <= merge(htime_reg, wdata_reg, wstrb_reg);
            IDX_VTIME:  vtime_reg  <= merge(vtime_reg, wdata_reg, wstrb_reg);
            IDX_SYNC:   sync_reg   <= merge(sync_reg, wdata_reg, wstrb_reg);
            IDX_SCROLL: scroll_reg <= merge(scroll_reg, wdata_reg, wstrb_reg) & SCROLL_WMASK;
            default:    ;
         endcase
      end
   end

   // Read channel
   always_comb
   begin
      rd_word   = '0;
      rd_mapped = 1'b1;
      unique case (araddr[11:2])
         IDX_TX_CTL: rd_word = {24'h0, tx_ctl_reg};
         IDX_CTL:    rd_word = {24'h0, ctl_reg};
         IDX_CFG:    rd_word = {24'h0, cfg_reg};
         IDX_HTIME:  rd_word = htime_reg;
         IDX_VTIME:  rd_word = vtime_reg;
         IDX_SYNC:   rd_word = sync_reg;
         IDX_SCROLL: rd_word = scroll_reg;
         IDX_STATUS: rd_word = {16'h0, frame_cnt_reg, 3'h0, enable, pattern_sel};
         default:    rd_mapped = 1'b0;
      endcase
   end

   assign arready = !rvalid_reg;
   assign rvalid  = rvalid_reg;
   assign rdata   = rdata_reg;
   assign rresp   = rresp_reg;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid_reg <= 1'b0;
         rdata_reg  <= '0;
         rresp_reg  <= RESP_OKAY;
      end
      else if (arvalid && arready)
      begin
         rvalid_reg <= 1'b1;
         rdata_reg  <= rd_word;
         rresp_reg  <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
      end
      else if (rready)
         rvalid_reg <= 1'b0;
   end

   // The block never gates enable on this bit; ordering is up to software
   assign serial_tx_power_down = tx_ctl_reg[0];

   // Divided pixel tick, free running
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         div_reg <= '0;
      else
         div_reg <= (div_reg == DW'(DIVIDE - 1)) ? '0 : div_reg + 1'b1;
   end

   assign div_tick  = div_reg == '0;
   assign pix_tick  = cfg_reg[CFG_EXTCLK] ? ext_pixel_valid : div_tick;
   // Clock source only counts under internal timing; a full FIFO stalls every pixel
   assign step      = enable && fifo_ready && (tsel ? pix_tick : ext_pixel_valid);
   assign ext_ready = enable && fifo_ready;

   video_timing_gen #(
      .CW (TIME_W)
   ) u_timing (
      .aclk        (aclk),
      .aresetn     (aresetn),
      .advance     (step && tsel),
      .restart     (!enable || !tsel),
      .h_total     (htime_reg[TIME_TOTAL_LSB +: TIME_W]),
      .h_active    (h_active),
      .v_total     (vtime_reg[TIME_TOTAL_LSB +: TIME_W]),
      .v_active    (v_active),
      .h_sync      (sync_reg[SYNC_HSW_LSB +: 8]),
      .v_sync      (sync_reg[SYNC_VSW_LSB +: 8]),
      .h_back      (sync_reg[SYNC_HBP_LSB +: 8]),
      .v_back      (sync_reg[SYNC_VBP_LSB +: 8]),
      .hs_high     (scroll_reg[SCROLL_HS_HIGH]),
      .vs_high     (scroll_reg[SCROLL_VS_HIGH]),
      .de          (tg_de),
      .hs          (tg_hs),
      .vs          (tg_vs),
      .frame_start (tg_frame)
   );

   assign cur_de      = tsel ? tg_de : ext_de;
   assign cur_hs      = tsel ? tg_hs : ext_hs;
   assign cur_vs      = tsel ? tg_vs : ext_vs;
   assign ext_vs_act  = ext_vs ~^ scroll_reg[SCROLL_VS_HIGH];
   assign frame_begin = step && (tsel ? tg_frame : (ext_vs_act && !prev_vs_reg));
   assign line_end    = step && !cur_de && prev_de_reg;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         prev_de_reg <= 1'b0;
         prev_vs_reg <= 1'b0;
      end
      else if (step)
      begin
         prev_de_reg <= cur_de;
         prev_vs_reg <= ext_vs_act;
      end
   end

   // Ramps by accumulation avoid a divider; assumes active size not below the step count
   assign levels = eight ? LEVELS_18 : LEVELS_24;

   always_ff @(posedge aclk)
   begin
      for (int k = 0; k < 4; k++)
      begin
         if (!aresetn)
            st_reg[k] <= '0;
         else if (k < 2 && step)
            st_reg[k] <= cur_de ? acc_step(st_reg[k], k == 0 ? levels : BAR_STEPS, h_active)
                                : '0;
         else if (k >= 2 && frame_begin)
            st_reg[k] <= '0;
         else if (k >= 2 && line_end)
            st_reg[k] <= acc_step(st_reg[k], k == 2 ? levels : BAR_STEPS, v_active);
      end
   end

   // Auto-scroll pattern and frame counter
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         scroll_pat_reg <= PAT_FIRST;
         frame_cnt_reg  <= '0;
      end
      else if (!auto)
      begin
         scroll_pat_reg <= ctl_reg[CTL_SEL_LSB +: 4];
         frame_cnt_reg  <= '0;
      end
      else if (frame_begin)
      begin
         if (frame_cnt_reg + 8'h01 >= scroll_reg[7:0])
         begin
            scroll_pat_reg <= (scroll_pat_reg >= PAT_CUSTOM || scroll_pat_reg < PAT_FIRST)
                              ? PAT_FIRST : scroll_pat_reg + 4'h1;
            frame_cnt_reg  <= '0;
         end
         else
            frame_cnt_reg <= frame_cnt_reg + 8'h01;
      end
   end

   assign pattern_sel = auto ? scroll_pat_reg : ctl_reg[CTL_SEL_LSB +: 4];
   assign h_ramp      = eight ? {st_reg[0][17:12], 2'b00} : st_reg[0][19:12];
   assign v_ramp      = eight ? {st_reg[2][17:12], 2'b00} : st_reg[2][19:12];
   assign ramp        = (pattern_sel < PAT_VSCALE_FIRST) ? h_ramp : v_ramp;

   always_comb
   begin
      base = RGB_BLACK;
      if (pattern_sel == PAT_WHITE)
         base = RGB_WHITE;
      else if (pattern_sel == PAT_RED)
         base = RGB_RED;
      else if (pattern_sel == PAT_GREEN)
         base = RGB_GREEN;
      else if (pattern_sel == PAT_BLUE)
         base = RGB_BLUE;
      else if (pattern_sel >= PAT_HSCALE_FIRST && pattern_sel <= PAT_VSCALE_LAST)
      begin
         unique case (2'(pattern_sel - PAT_HSCALE_FIRST))
            2'h0: base = {ramp, ramp, ramp};
            2'h1: base = {ramp, 8'h00, 8'h00};
            2'h2: base = {8'h00, ramp, 8'h00};
            2'h3: base = {8'h00, 8'h00, ramp};
         endcase
      end
      else if (pattern_sel == PAT_CUSTOM)
         base = CUSTOM;
      else if (pattern_sel == PAT_BANDS)
         base = ctl_reg[CTL_REVERSE] ? BANDS_REVERSE[{st_reg[3][14], st_reg[1][14]}]
                                     : BANDS_NORMAL[{st_reg[3][14], st_reg[1][14]}];
      if (ctl_reg[CTL_BARS])
         base = BAR_COLOURS[st_reg[1][14:12]];
   end

   always_comb
   begin
      shown = cfg_reg[CFG_INVERT] ? ~base : base;
      if (eight)
         shown = shown & {MASK_18, MASK_18, MASK_18};
      if (!cur_de)
         shown = RGB_BLACK;
   end

   assign pixel = {cur_de, cur_hs, cur_vs, shown};

   pixel_fifo #(
      .WIDTH (PIX_W),
      .DEPTH (DEPTH)
   ) u_fifo (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .in_valid  (step),
      .in_ready  (fifo_ready),
      .in_data   (pixel),
      .out_valid (video_valid),
      .out_ready (video_ready),
      .out_data  (out_word)
   );

   assign video_de    = out_word[26];
   assign video_hs    = out_word[25];
   assign video_vs    = out_word[24];
   assign video_red   = out_word[23:16];
   assign video_green = out_word[15:8];
   assign video_blue  = out_word[7:0];
endmodule : pattern_generator

/* File: core/pattern_gen_pkg.sv */
package pattern_gen_pkg;
   // Register indices; the byte address is four times the index
   localparam logic [9:0]  IDX_TX_CTL       = 10'h063;
   localparam logic [9:0]  IDX_CTL          = 10'h064;
   localparam logic [9:0]  IDX_CFG          = 10'h065;
   localparam logic [9:0]  IDX_HTIME        = 10'h070;
   localparam logic [9:0]  IDX_VTIME        = 10'h071;
   localparam logic [9:0]  IDX_SYNC         = 10'h072;
   localparam logic [9:0]  IDX_SCROLL       = 10'h073;
   localparam logic [9:0]  IDX_STATUS       = 10'h074;
   // Reset values
   localparam logic [7:0]  TX_CTL_RESET     = 8'h00;
   localparam logic [7:0]  CTL_RESET        = 8'h10;
   localparam logic [7:0]  CFG_RESET        = 8'h00;
   localparam logic [31:0] HTIME_RESET      = 32'h0280_0320;
   localparam logic [31:0] VTIME_RESET      = 32'h01e0_020d;
   localparam logic [31:0] SYNC_RESET       = 32'h2130_0260;
   localparam logic [31:0] SCROLL_RESET     = 32'h0000_003c;
   // Field positions
   localparam int          CTL_ENABLE       = 0;
   localparam int          CTL_REVERSE      = 1;
   localparam int          CTL_BARS         = 2;
   localparam int          CTL_SEL_LSB      = 4;
   localparam int          CFG_AUTO         = 0;
   localparam int          CFG_INVERT       = 1;
   localparam int          CFG_TSEL         = 2;
   localparam int          CFG_EXTCLK       = 3;
   localparam int          CFG_18B          = 4;
   localparam logic [7:0]  CFG_WMASK        = 8'h1f;
   localparam int          TIME_TOTAL_LSB   = 0;
   localparam int          TIME_ACTIVE_LSB  = 16;
   localparam int          TIME_W           = 12;
   localparam int          SYNC_HSW_LSB     = 0;
   localparam int          SYNC_VSW_LSB     = 8;
   localparam int          SYNC_HBP_LSB     = 16;
   localparam int          SYNC_VBP_LSB     = 24;
   localparam int          SCROLL_HS_HIGH   = 8;
   localparam int          SCROLL_VS_HIGH   = 9;
   localparam logic [31:0] SCROLL_WMASK     = 32'h0000_03ff;
   // Pattern codes
   localparam logic [3:0]  PAT_WHITE        = 4'h1;
   localparam logic [3:0]  PAT_BLACK        = 4'h2;
   localparam logic [3:0]  PAT_RED          = 4'h3;
   localparam logic [3:0]  PAT_GREEN        = 4'h4;
   localparam logic [3:0]  PAT_BLUE         = 4'h5;
   localparam logic [3:0]  PAT_HSCALE_FIRST = 4'h6;
   localparam logic [3:0]  PAT_VSCALE_FIRST = 4'ha;
   localparam logic [3:0]  PAT_VSCALE_LAST  = 4'hd;
   localparam logic [3:0]  PAT_CUSTOM       = 4'he;
   localparam logic [3:0]  PAT_BANDS        = 4'hf;
   localparam logic [3:0]  PAT_FIRST        = 4'h1;
   // Brightness steps
   localparam logic [8:0]  LEVELS_24        = 9'h100;
   localparam logic [8:0]  LEVELS_18        = 9'h040;
   localparam logic [8:0]  BAR_STEPS        = 9'h008;
   localparam logic [7:0]  MASK_18          = 8'hfc;
   // Colours
   localparam logic [23:0] RGB_WHITE        = 24'hffffff;
   localparam logic [23:0] RGB_YELLOW       = 24'hffff00;
   localparam logic [23:0] RGB_CYAN         = 24'h00ffff;
   localparam logic [23:0] RGB_GREEN        = 24'h00ff00;
   localparam logic [23:0] RGB_MAGENTA      = 24'hff00ff;
   localparam logic [23:0] RGB_RED          = 24'hff0000;
   localparam logic [23:0] RGB_BLUE         = 24'h0000ff;
   localparam logic [23:0] RGB_BLACK        = 24'h000000;
   localparam logic [23:0] BAR_COLOURS [8]  = '{RGB_WHITE, RGB_YELLOW, RGB_CYAN, RGB_GREEN,
                                                RGB_MAGENTA, RGB_RED, RGB_BLUE, RGB_BLACK};
   localparam logic [23:0] BANDS_NORMAL [4] = '{RGB_YELLOW, RGB_CYAN, RGB_BLUE, RGB_RED};
   localparam logic [23:0] BANDS_REVERSE [4] = '{RGB_BLUE, RGB_CYAN, RGB_YELLOW, RGB_RED};
   // Bus answers, divider and stream shape
   localparam logic [1:0]  RESP_OKAY        = 2'b00;
   localparam logic [1:0]  RESP_SLVERR      = 2'b10;
   localparam int          DIV_DEFAULT      = 4;
   localparam int          FIFO_DEPTH       = 8;
   localparam int          PIX_W            = 27;
endpackage : pattern_gen_pkg

/* File: core/pixel_fifo.sv */
`timescale 1ns/1ps
module pixel_fifo #(
   parameter int WIDTH = 27,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input  wire logic             aclk,
   input  wire logic             aresetn,
   // Fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0]    wr_ptr_reg;
   logic [AW-1:0]    rd_ptr_reg;
   logic [AW:0]      count_reg;
   logic             push;
   logic             pop;

   assign in_ready  = count_reg != (AW+1)'(DEPTH);
   assign out_valid = count_reg != '0;
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_data  = mem_reg[rd_ptr_reg];

   always_ff @(posedge aclk)
   begin
      if (push)
         mem_reg[wr_ptr_reg] <= in_data;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         wr_ptr_reg <= '0;
      else if (push)
         wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         rd_ptr_reg <= '0;
      else if (pop)
         rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         count_reg <= '0;
      else if (push && !pop)
         count_reg <= count_reg + 1'b1;
      else if (pop && !push)
         count_reg <= count_reg - 1'b1;
   end
endmodule : pixel_fifo

/* File: core/video_timing_gen.sv */
`timescale 1ns/1ps
module video_timing_gen #(
   parameter int CW = 12
) (
   // Clock and reset
   input  wire logic          aclk,
   input  wire logic          aresetn,
   // Control
   input  wire logic          advance,
   input  wire logic          restart,
   // Frame shape
   input  wire logic [CW-1:0] h_total,
   input  wire logic [CW-1:0] h_active,
   input  wire logic [CW-1:0] v_total,
   input  wire logic [CW-1:0] v_active,
   input  wire logic [7:0]    h_sync,
   input  wire logic [7:0]    v_sync,
   input  wire logic [7:0]    h_back,
   input  wire logic [7:0]    v_back,
   input  wire logic          hs_high,
   input  wire logic          vs_high,
   // Timing
   output logic               de,
   output logic               hs,
   output logic               vs,
   output logic               frame_start
);
   logic [CW-1:0] h_cnt_reg;
   logic [CW-1:0] v_cnt_reg;
   logic [CW-1:0] h_start;
   logic [CW-1:0] v_start;
   logic          line_last;

   assign h_start     = CW'(h_sync) + CW'(h_back);
   assign v_start     = CW'(v_sync) + CW'(v_back);
   assign line_last   = h_cnt_reg == h_total - 1'b1;
   assign de          = h_cnt_reg >= h_start && h_cnt_reg < h_start + h_active
                        && v_cnt_reg >= v_start && v_cnt_reg < v_start + v_active;
   assign hs          = (h_cnt_reg < CW'(h_sync)) ~^ hs_high;
   assign vs          = (v_cnt_reg < CW'(v_sync)) ~^ vs_high;
   assign frame_start = h_cnt_reg == '0 && v_cnt_reg == '0;

   always_ff @(posedge aclk)
   begin
      if (!aresetn || restart)
         h_cnt_reg <= '0;
      else if (advance)
         h_cnt_reg <= line_last ? '0 : h_cnt_reg + 1'b1;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn || restart)
         v_cnt_reg <= '0;
      else if (advance && line_last)
         v_cnt_reg <= (v_cnt_reg == v_total - 1'b1) ? '0 : v_cnt_reg + 1'b1;
   end
endmodule : video_timing_gen

/* File: verification/pattern_checker_properties.sv */
`timescale 1ns/1ps
module pattern_checker (
   input wire logic       aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready,
   input wire logic       arvalid, arready, rvalid, rready, video_valid, video_ready,
   input wire logic       video_de, ext_ready,
   input wire logic [7:0] video_red, video_green, video_blue
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_b_ans; awvalid && awready && wvalid && wready |-> ##[1:2] bvalid; endproperty
   a_b_ans: assert property (p_b_ans) else $error("write unanswered");
   property p_b_end; bvalid && bready |=> !bvalid; endproperty
   a_b_end: assert property (p_b_end) else $error("bvalid stuck");
   property p_r_ans; arvalid && arready |=> rvalid; endproperty
   a_r_ans: assert property (p_r_ans) else $error("read unanswered");
   property p_r_end; rvalid && rready |=> !rvalid; endproperty
   a_r_end: assert property (p_r_end) else $error("rvalid stuck");
   property p_ar_blk; rvalid |-> !arready; endproperty
   a_ar_blk: assert property (p_ar_blk) else $error("read taken while busy");
   property p_v_hold;
      video_valid && !video_ready |=> video_valid && $stable({video_de, video_red});
   endproperty
   a_v_hold: assert property (p_v_hold) else $error("pixel dropped");
   property p_blank; video_valid && !video_de |-> {video_red, video_blue} == 16'h0000; endproperty
   a_blank: assert property (p_blank) else $error("blank not black");
   property p_idle; $rose(aresetn) |-> !video_valid && !ext_ready && !bvalid; endproperty
   a_idle: assert property (p_idle) else $error("busy after reset");
   c_wr: cover property (bvalid && bready);
   c_rd: cover property (rvalid && rready);
   c_pix: cover property (video_valid && video_ready && video_de);
endmodule : pattern_checker
bind pattern_generator pattern_checker chk (.*);

/* File: verification/video_sink.sv */
`timescale 1ns/1ps
module video_sink (
   input  wire logic aclk,
   input  wire logic stall,
   output logic      video_ready
);
   // Registered, so a stall lands cleanly on an edge as a real downstream path would
   always_ff @(posedge aclk) video_ready <= !stall;
endmodule : video_sink

/* File: verification/testbench.sv */
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin err_total++; $display("[ERR] %0t got %h want %h", $time, a, e); end end
module testbench
   import pattern_gen_pkg::*;
;
   logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
   logic        rready = 0, ext_pixel_valid = 0, ext_de = 1, ext_hs = 0, ext_vs = 0, stall = 0;
   logic        awready, wready, bvalid, arready, rvalid, ext_ready, video_valid, video_ready;
   logic        video_de, video_hs, video_vs, serial_tx_power_down;
   logic [11:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata;
   logic [3:0]  wstrb = 4'hf;
   logic [1:0]  bresp, rresp;
   logic [7:0]  video_red, video_green, video_blue;
   int          err_total = 0, tests_run = 0;
   always #2 aclk = ~aclk;
   always @(posedge aclk) ext_pixel_valid <= ~ext_pixel_valid;
   pattern_generator dut (.*);
   video_sink sink (.aclk(aclk), .stall(stall), .video_ready(video_ready));
   task automatic wrap_up;
      $display("checks %0d errors %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : wrap_up
   task automatic hang;
      err_total++;
      $display("[ERR] %0t timeout", $time);
      wrap_up();
   endtask : hang
   task automatic wr(input logic [9:0] idx, input logic [31:0] d);
      int n = 0;
      @(posedge aclk);
      awaddr <= {idx, 2'b00};
      wdata <= d;
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      do
      begin
         @(posedge aclk);
         n++;
         if (awready) awvalid <= 0;
         if (wready) wvalid <= 0;
      end while (bvalid !== 1 && n < 50);
      bready <= 0;
      if (n >= 50) hang();
      `CHK(bresp, RESP_OKAY)
   endtask : wr
   task automatic rd(input logic [9:0] idx, input logic [31:0] e, input logic [1:0] r);
      int n = 0;
      @(posedge aclk);
      araddr <= {idx, 2'b00};
      arvalid <= 1;
      rready <= 1;
      do
      begin
         @(posedge aclk);
         n++;
         if (arready) arvalid <= 0;
      end while (rvalid !== 1 && n < 50);
      rready <= 0;
      if (n >= 50) hang();
      `CHK(rdata, e)
      `CHK(rresp, r)
   endtask : rd
   task automatic get_pix(input logic [23:0] e);
      int n = 0;
      do
      begin
         @(posedge aclk);
         n++;
      end while (!(video_valid === 1 && video_ready === 1 && video_de === 1) && n < 400);
      if (n >= 400) hang();
      `CHK({video_hs, video_vs, video_red, video_green, video_blue}, {2'b11, e})
   endtask : get_pix
   initial
   begin
      repeat (6) @(posedge aclk);
      aresetn <= 1;
      rd(IDX_CTL, 32'h10, RESP_OKAY);
      rd(IDX_CFG, 32'h00, RESP_OKAY);
      rd(10'h3ff, 32'h0, RESP_SLVERR);
      wr(IDX_CFG, 32'hff);
      rd(IDX_CFG, 32'h1f, RESP_OKAY);
      wr(IDX_TX_CTL, 32'h1);
      `CHK(serial_tx_power_down, 1'b1)
      wr(IDX_HTIME, 32'h0008_000c);
      wr(IDX_VTIME, 32'h0002_0004);
      wr(IDX_SYNC, 32'h0101_0101);
      wr(IDX_CFG, 32'h04);
      wr(IDX_CTL, 32'h15);
      for (int i = 0; i < 8; i++) get_pix(BAR_COLOURS[i]);
      wr(IDX_CTL, 32'hf2);
      repeat (20) @(posedge aclk);
      wr(IDX_CTL, 32'hf3);
      get_pix(RGB_BLUE);
      wr(IDX_CTL, 32'h30);
      repeat (20) @(posedge aclk);
      wr(IDX_CFG, 32'h16);
      wr(IDX_CTL, 32'h31);
      get_pix(24'h00fcfc);
      wr(IDX_CTL, 32'h30);
      repeat (20) @(posedge aclk);
      stall <= 1;
      wr(IDX_CFG, 32'h0c);
      wr(IDX_CTL, 32'h31);
      repeat (20) @(posedge aclk);
      `CHK(ext_ready, 1'b0)
      wr(IDX_CTL, 32'h30);
      stall <= 0;
      repeat (20) @(posedge aclk);
      stall <= 1;
      wr(IDX_CFG, 32'h00);
      wr(IDX_CTL, 32'h31);
      repeat (20) @(posedge aclk);
      `CHK(ext_ready, 1'b0)
      `CHK(video_valid, 1'b1)
      stall <= 0;
      wr(IDX_CTL, 32'h30);
      repeat (30) @(posedge aclk);
      `CHK(video_valid, 1'b0)
      wr(IDX_SCROLL, 32'h2);
      wr(IDX_CTL, 32'h50);
      wr(IDX_CFG, 32'h05);
      wr(IDX_CTL, 32'h51);
      repeat (90) @(posedge aclk);
      rd(IDX_STATUS, 32'h115, RESP_OKAY);
      repeat (190) @(posedge aclk);
      rd(IDX_STATUS, 32'h16, RESP_OKAY);
      wr(IDX_CFG, 32'h04);
      rd(IDX_STATUS, 32'h15, RESP_OKAY);
      wrap_up();
   end
endmodule : testbench
